// ---- logic/sgcr_global_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sgcr_map.svh"

module sgcr_global_ctrl
    import sgcr_pkg::*;
#(
    parameter int unsigned PERIOD_FAST_CYC = `SGCR_PERIOD_FAST_CYC,
    parameter int unsigned PERIOD_SLOW_CYC = `SGCR_PERIOD_SLOW_CYC
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            nrst_i,
    // Strap pins
    input  wire logic            flow_ctrl_strap_pin_i,
    input  wire logic            speed_strap_pin_i,
    input  wire logic            led_mode_strap_pin_i,
    input  wire logic            size_check_strap_pin_i,
    // Register access
    input  wire sgcr_wr_s        reg_req_i,
    output logic      [7:0]      reg_rdata_o,
    // Switch MII controls
    output logic                 flow_ctrl_en_o,
    output logic                 ten_megabit_mode_o,
    output logic                 special_tpid_en_o,
    // Null VID replacement
    input  wire logic     [11:0] rx_vid_i,
    input  wire logic     [11:0] port_vid_i,
    output logic          [11:0] vid_o,
    // Broadcast storm
    output logic          [10:0] storm_threshold_o,
    output logic                 tick_hundred_o,
    output logic                 tick_ten_o,
    // Frame size check
    input  wire logic     [10:0] frame_len_i,
    input  wire logic            frame_tagged_i,
    output logic                 frame_drop_o,
    // LEDs
    input  wire sgcr_port_s [4:0] port_state_i,
    output logic           [4:0] port_led_two_o,
    output logic           [4:0] port_led_one_o,
    output logic           [4:0] port_led_zero_o
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  ctrl4;
    logic [7:0]  storm_low;
    logic [7:0]  ftest_a;
    logic [7:0]  ftest_b;
    logic [7:0]  ftest_c;
    logic [1:0]  led_tpid;
    logic        size_check_off;
    sgcr_state_e state;

    function automatic logic hit(input sgcr_wr_s r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // Straps cannot be loaded under async reset; catch them at the first edge after release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= SGCR_LOAD_STRAPS;
        end else begin
            state <= SGCR_RUN;
        end
    end

    // A write in the strap-load cycle wins over the strap
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl4 <= `SGCR_RST_CTRL4;
        end else if (hit(reg_req_i, `SGCR_OFS_CTRL4)) begin
            ctrl4 <= reg_req_i.data;
        end else if (state == SGCR_LOAD_STRAPS) begin
            ctrl4[`SGCR_BIT_FLOW]    <= flow_ctrl_strap_pin_i;
            ctrl4[`SGCR_BIT_SPEED10] <= speed_strap_pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            led_tpid <= 2'(`SGCR_RST_LED_TPID);
        end else if (hit(reg_req_i, `SGCR_OFS_LED_TPID)) begin
            led_tpid <= reg_req_i.data[1:0];
        end else if (state == SGCR_LOAD_STRAPS) begin
            led_tpid[`SGCR_BIT_LED_MODE] <= led_mode_strap_pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            size_check_off <= 1'b0;
        end else if (state == SGCR_LOAD_STRAPS) begin
            size_check_off <= size_check_strap_pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            storm_low <= `SGCR_RST_STORM_LOW;
            ftest_a   <= `SGCR_RST_FTEST_A;
            ftest_b   <= `SGCR_RST_FTEST_B;
            ftest_c   <= `SGCR_RST_FTEST_C;
        end else begin
            if (hit(reg_req_i, `SGCR_OFS_STORM_LOW)) storm_low <= reg_req_i.data;
            if (hit(reg_req_i, `SGCR_OFS_FTEST_A))   ftest_a   <= reg_req_i.data;
            if (hit(reg_req_i, `SGCR_OFS_FTEST_B))   ftest_b   <= reg_req_i.data;
            if (hit(reg_req_i, `SGCR_OFS_FTEST_C))   ftest_c   <= reg_req_i.data;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        unique case (reg_req_i.addr)
            `SGCR_OFS_CTRL4:     next_rdata = ctrl4;
            `SGCR_OFS_STORM_LOW: next_rdata = storm_low;
            `SGCR_OFS_FTEST_A:   next_rdata = ftest_a;
            `SGCR_OFS_FTEST_B:   next_rdata = ftest_b;
            `SGCR_OFS_FTEST_C:   next_rdata = ftest_c;
            `SGCR_OFS_LED_TPID:  next_rdata = {6'h00, led_tpid};
            default:             next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    assign flow_ctrl_en_o     = ctrl4[`SGCR_BIT_FLOW];
    assign ten_megabit_mode_o = ctrl4[`SGCR_BIT_SPEED10];
    assign special_tpid_en_o  = led_tpid[`SGCR_BIT_TPID];
    assign storm_threshold_o  = {ctrl4[2:0], storm_low};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vid_o <= 12'h000;
        end else if (ctrl4[`SGCR_BIT_NULLVID] && (rx_vid_i == 12'h000)) begin
            vid_o <= port_vid_i;
        end else begin
            vid_o <= rx_vid_i;
        end
    end

    // ----------------------------------------
    // Storm measurement periods
    // ----------------------------------------
    logic [25:0] cnt_fast;
    logic [25:0] cnt_slow;

    // Both periods run free so ports at either speed always have a window
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_fast       <= 26'h0000000;
            cnt_slow       <= 26'h0000000;
            tick_hundred_o <= 1'b0;
            tick_ten_o     <= 1'b0;
        end else begin
            tick_hundred_o <= (cnt_fast == 26'(PERIOD_FAST_CYC - 1));
            tick_ten_o     <= (cnt_slow == 26'(PERIOD_SLOW_CYC - 1));
            cnt_fast <= (cnt_fast == 26'(PERIOD_FAST_CYC - 1)) ? 26'h0000000 : cnt_fast + 26'h1;
            cnt_slow <= (cnt_slow == 26'(PERIOD_SLOW_CYC - 1)) ? 26'h0000000 : cnt_slow + 26'h1;
        end
    end

    // ----------------------------------------
    // Frame size check and LEDs
    // ----------------------------------------
    logic [10:0] max_len;

    // Special-TPID frames from the CPU carry an extra tag, so the relaxed limit applies
    always_comb begin
        if (size_check_off || special_tpid_en_o) begin
            max_len = `SGCR_MAX_RELAXED;
        end else if (frame_tagged_i) begin
            max_len = `SGCR_MAX_TAGGED;
        end else begin
            max_len = `SGCR_MAX_UNTAGGED;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_drop_o <= 1'b0;
        end else begin
            frame_drop_o <= (frame_len_i > max_len);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_led_two_o  <= 5'h00;
            port_led_one_o  <= 5'h00;
            port_led_zero_o <= 5'h00;
        end else begin
            for (int p = 0; p < 5; p++) begin
                if (led_tpid[`SGCR_BIT_LED_MODE]) begin
                    port_led_two_o[p]  <= port_state_i[p].link && port_state_i[p].speed100;
                    port_led_one_o[p]  <= port_state_i[p].link && !port_state_i[p].speed100;
                    port_led_zero_o[p] <= port_state_i[p].full_duplex;
                end else begin
                    port_led_two_o[p]  <= port_state_i[p].link;
                    port_led_one_o[p]  <= port_state_i[p].full_duplex;
                    port_led_zero_o[p] <= port_state_i[p].speed100;
                end
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence ctrl4_write_s;
        hit(reg_req_i, `SGCR_OFS_CTRL4);
    endsequence

    sequence strap_cycle_s;
        (state == SGCR_LOAD_STRAPS) && !hit(reg_req_i, `SGCR_OFS_CTRL4);
    endsequence

    flow_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ctrl4_write_s |=> flow_ctrl_en_o == $past(reg_req_i.data[5]))
        else $error("flow control bit not written");
    flow_strap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        strap_cycle_s |=> flow_ctrl_en_o == $past(flow_ctrl_strap_pin_i))
        else $error("flow control strap not loaded");
    speed_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ctrl4_write_s |=> ten_megabit_mode_o == $past(reg_req_i.data[4]))
        else $error("speed bit not written");
    speed_strap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        strap_cycle_s |=> ten_megabit_mode_o == $past(speed_strap_pin_i))
        else $error("speed strap not loaded");
    null_vid_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (ctrl4[3] && rx_vid_i == 12'h000) |=> vid_o == $past(port_vid_i))
        else $error("null VID not replaced");
    thresh_form_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        hit(reg_req_i, `SGCR_OFS_STORM_LOW) |=> storm_threshold_o[7:0] == $past(reg_req_i.data))
        else $error("threshold low byte wrong");
    tick_gap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tick_hundred_o |=> !tick_hundred_o [*8])
        else $error("storm period tick too close");
    thresh_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(state == SGCR_RUN) |-> $past(storm_threshold_o) == 11'h04A)
        else $error("threshold reset value wrong");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_req_i.addr == `SGCR_OFS_LED_TPID |=> reg_rdata_o[7:2] == 6'h00)
        else $error("reserved LED bits not zero");
    led_mode_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !led_tpid[1] ##1 !led_tpid[1] |-> port_led_two_o == $past({port_state_i[4].link,
            port_state_i[3].link, port_state_i[2].link, port_state_i[1].link,
            port_state_i[0].link}))
        else $error("mode 0 link LED wrong");
    oversize_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!size_check_off && !special_tpid_en_o && !frame_tagged_i && frame_len_i > 11'h5EE)
        |=> frame_drop_o)
        else $error("oversize frame not dropped");

endmodule : sgcr_global_ctrl

`default_nettype wire

// ---- logic/sgcr_map.svh ----
`ifndef SGCR_MAP_SVH
`define SGCR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SGCR_OFS_CTRL4      8'h06
`define SGCR_OFS_STORM_LOW  8'h07
`define SGCR_OFS_FTEST_A    8'h08
`define SGCR_OFS_FTEST_B    8'h09
`define SGCR_OFS_FTEST_C    8'h0A
`define SGCR_OFS_LED_TPID   8'h0B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SGCR_BIT_FLOW       5
`define SGCR_BIT_SPEED10    4
`define SGCR_BIT_NULLVID    3
`define SGCR_BIT_LED_MODE   1
`define SGCR_BIT_TPID       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SGCR_RST_CTRL4      8'h00
`define SGCR_RST_STORM_LOW  8'h4A
`define SGCR_RST_FTEST_A    8'h24
`define SGCR_RST_FTEST_B    8'h28
`define SGCR_RST_FTEST_C    8'h24
`define SGCR_RST_LED_TPID   8'h00

// ----------------------------------------
// Timing and frame limits
// ----------------------------------------
`define SGCR_CLK_KHZ            125000
`define SGCR_PERIOD_FAST_MS     50
`define SGCR_PERIOD_SLOW_MS     500
`define SGCR_PERIOD_FAST_CYC    (`SGCR_PERIOD_FAST_MS * `SGCR_CLK_KHZ)
`define SGCR_PERIOD_SLOW_CYC    (`SGCR_PERIOD_SLOW_MS * `SGCR_CLK_KHZ)
`define SGCR_MAX_TAGGED         11'h5F2
`define SGCR_MAX_UNTAGGED       11'h5EE
`define SGCR_MAX_RELAXED        11'h600

`endif

// ---- logic/sgcr_pkg.sv ----
package sgcr_pkg;

    // Host register access, one request per cycle
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } sgcr_wr_s;

    // Per-port link state used by the LED display
    typedef struct packed {
        logic link;
        logic act;
        logic full_duplex;
        logic col;
        logic speed100;
    } sgcr_port_s;

    typedef enum logic [0:0] {
        SGCR_LOAD_STRAPS = 1'b0,
        SGCR_RUN         = 1'b1
    } sgcr_state_e;

endpackage : sgcr_pkg

// ---- tb/sgcr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module sgcr_host_model
    import sgcr_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Register port
    input  wire logic [7:0] rdata_i,
    output var  sgcr_wr_s   req_o
);
    // --------------------------------
    // Host register cycles
    // --------------------------------
    initial req_o = '{1'b0, 8'h00, 8'h00};

    task wr(input logic [7:0] a, input logic [7:0] d);
        // Test registers are never written by software
        if (a inside {8'h08, 8'h09, 8'h0A}) return;
        @(posedge clk_i);
        #1 req_o = '{1'b1, a, d};
        @(posedge clk_i);
        // Data turned over once released so a held value is not relied on
        #1 req_o = '{1'b0, a, ~d};
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = '{1'b0, a, ~req_o.data};
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask : rd
endmodule : sgcr_host_model

`default_nettype wire

// ---- tb/test_switch_global_control_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_switch_global_control_regs
    import sgcr_pkg::*;
;
    logic             clk_i, nrst_i, flow, ten, tpid, tk100, tk10, ftag, drop;
    logic [3:0]       strap;
    sgcr_wr_s         req;
    logic [7:0]       rdata, r6, r7, rb, d, a;
    logic [11:0]      rx_vid, port_vid, vid;
    logic [10:0]      thr, flen;
    sgcr_port_s [4:0] ps;
    logic [4:0]       l2, l1, l0;
    int               err_total, tests_run, seed, n100, n10;
    int               lens [8] = '{1518, 1519, 1522, 1523, 1536, 1537, 0, 2047};
    logic [7:0]       ca [4] = '{8'h06, 8'h07, 8'h0B, 8'h0C};
    logic [7:0]       cd [4] = '{8'h07, 8'hFF, 8'hFF, 8'h55};

    // Short periods keep the tick window small
    sgcr_global_ctrl #(.PERIOD_FAST_CYC(16), .PERIOD_SLOW_CYC(40)) u_sgcr_global_ctrl (
        .clk_i(clk_i), .nrst_i(nrst_i), .flow_ctrl_strap_pin_i(strap[3]),
        .speed_strap_pin_i(strap[2]), .led_mode_strap_pin_i(strap[1]),
        .size_check_strap_pin_i(strap[0]), .reg_req_i(req), .reg_rdata_o(rdata),
        .flow_ctrl_en_o(flow), .ten_megabit_mode_o(ten), .special_tpid_en_o(tpid),
        .rx_vid_i(rx_vid), .port_vid_i(port_vid), .vid_o(vid), .storm_threshold_o(thr),
        .tick_hundred_o(tk100), .tick_ten_o(tk10), .frame_len_i(flen),
        .frame_tagged_i(ftag), .frame_drop_o(drop), .port_state_i(ps),
        .port_led_two_o(l2), .port_led_one_o(l1), .port_led_zero_o(l0));

    sgcr_host_model u_sgcr_host_model (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // --------------------------------
    // Helpers
    // --------------------------------
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task rst(input logic [3:0] s);
        @(posedge clk_i);
        #1 nrst_i = 1'b0;
        strap = s;
        repeat (20) @(posedge clk_i);
        #1 nrst_i = 1'b1;
    endtask : rst

    task rchk(input logic [7:0] ad, input logic [7:0] e);
        u_sgcr_host_model.rd(ad, d);
        chk("read", {8'h00, d}, {8'h00, e});
    endtask : rchk

    function automatic logic [15:0] f_led(input sgcr_port_s [4:0] p, input logic m);
        logic [4:0] t, o, z;
        for (int i = 0; i < 5; i++) begin
            t[i] = m ? p[i].link & p[i].speed100 : p[i].link;
            o[i] = m ? p[i].link & ~p[i].speed100 : p[i].full_duplex;
            z[i] = m ? p[i].full_duplex : p[i].speed100;
        end
        return {1'b0, t, o, z};
    endfunction : f_led

    task datapath(input int k);
        for (int i = 0; i < k; i++) begin
            rx_vid = ($random(seed) & 1) ? 12'h000 : 12'($random(seed));
            port_vid = 12'($random(seed));
            flen = 11'(lens[$random(seed) & 7]);
            ftag = 1'($random(seed));
            ps = 25'($random(seed));
            @(posedge clk_i);
            #1 chk("vid", {4'h0, vid}, {4'h0, (r6[3] && rx_vid == 0) ? port_vid : rx_vid});
            chk("drop", {15'h0, drop}, {15'h0, flen > ((strap[0] | rb[0]) ? 1536 : ftag ? 1522 : 1518)});
            chk("leds", {1'b0, l2, l1, l0}, f_led(ps, rb[1]));
        end
    endtask : datapath

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        seed = 64498;
        {err_total, tests_run} = '0;
        {nrst_i, strap, rx_vid, port_vid, flen, ftag, ps} = '0;
        rst(4'h0);
        rchk(8'h06, 8'h00);
        rchk(8'h07, 8'h4A);
        rchk(8'h08, 8'h24);
        rchk(8'h09, 8'h28);
        rchk(8'h0A, 8'h24);
        rchk(8'h0B, 8'h00);
        rchk(8'h0C, 8'h00);
        chk("threshold", {5'h0, thr}, 16'h004A);
        $display("Test reset values done");
        rst(4'hF);
        {r6, r7, rb} = {8'h30, 8'h4A, 8'h02};
        rchk(8'h06, 8'h30);
        rchk(8'h0B, 8'h02);
        chk("flow", {15'h0, flow}, 16'h0001);
        chk("speed", {15'h0, ten}, 16'h0001);
        datapath(20);
        u_sgcr_host_model.wr(8'h06, 8'h00);
        rchk(8'h06, 8'h00);
        $display("Test straps done");
        rst(4'h0);
        {r6, r7, rb} = {8'h00, 8'h4A, 8'h00};
        for (int i = 0; i < 40; i++) begin
            a = (i < 4) ? ca[i] : ca[$random(seed) & 3];
            d = (i < 4) ? cd[i] : 8'($random(seed));
            u_sgcr_host_model.wr(a, d);
            case (a)
                8'h06: r6 = d;
                8'h07: r7 = d;
                8'h0B: rb = d & 8'h03;
                default: ;
            endcase
            rchk(a, (a == 8'h06) ? r6 : (a == 8'h07) ? r7 : (a == 8'h0B) ? rb : 8'h00);
            chk("flow", {15'h0, flow}, {15'h0, r6[5]});
            chk("speed", {15'h0, ten}, {15'h0, r6[4]});
            chk("threshold", {5'h0, thr}, {5'h0, r6[2:0], r7});
            chk("tpid", {15'h0, tpid}, {15'h0, rb[0]});
            datapath(4);
        end
        $display("Test register writes done");
        {n100, n10} = '0;
        repeat (640) begin
            @(posedge clk_i);
            #1 n100 += int'(tk100);
            n10 += int'(tk10);
        end
        chk("hundred ticks", 16'(n100), 16'h0028);
        chk("ten ticks", 16'(n10), 16'h0010);
        $display("Test period ticks done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        end_of_test();
    end
endmodule : test_switch_global_control_regs

`default_nettype wire
